// ---- ipf_pkg.sv ----
package ipf_pkg;

  // ==========================================================================
  // Register map (byte addresses on the 32-bit bus)
  // ==========================================================================
  localparam logic [3:0] ADDR_PRIO0 = 4'h0;
  localparam logic [3:0] ADDR_PRIO1 = 4'h4;
  localparam int         ADDR_W     = 4;
  localparam int         REG_W      = 16;
  localparam int         FIELD_W    = 3;

  // ==========================================================================
  // Field positions (least significant bit of each three-bit field)
  // ==========================================================================
  localparam int OUT_CMP1_LSB = 8;
  localparam int IN_CAP1_LSB  = 4;
  localparam int EXT_IRQ0_LSB = 0;
  localparam int TIMER2_LSB   = 12;
  localparam int OUT_CMP2_LSB = 8;
  localparam int IN_CAP2_LSB  = 4;

  // ==========================================================================
  // Implemented-bit masks and reset values
  // ==========================================================================
  localparam logic [15:0] PRIO0_MASK  = 16'h0777;
  localparam logic [15:0] PRIO1_MASK  = 16'h7770;
  localparam logic [2:0]  FIELD_RESET = 3'h4;
  localparam logic [2:0]  LEVEL_OFF   = 3'h0;

  // ==========================================================================
  // Bus responses
  // ==========================================================================
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// ---- ipf_prio_field.sv ----
`timescale 1ns/1ns
// One priority field: stores the code and turns it into a level and enable.
module ipf_prio_field (
  // Clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // Write side
  input  wire logic       wr_en,
  input  wire logic [2:0] wr_code,
  // Field outputs
  output logic      [2:0] code,
  output logic      [2:0] level,
  output logic            enabled
);

  logic [2:0] next_code;

  always_comb begin
    next_code = wr_en ? wr_code : code;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code <= ipf_pkg::FIELD_RESET;
    end else begin
      code <= next_code;
    end
  end

  // The code is the level itself; all zeros means the source is off.
  assign level   = code;
  assign enabled = code != ipf_pkg::LEVEL_OFF;

endmodule

// ---- ipf_regs.sv ----
`timescale 1ns/1ns
// ============================================================================
// What this block does
// - A field's three-bit value is its level; seven highest, one lowest.
// - Field value zero disables the source; it is never offered.
// - Unimplemented bits of both priority registers always read zero.
// - First register holds output compare 1 priority in bits 10 to 8.
// - First register bit 7 unused; input capture 1 priority in bits 6 to 4.
// - First register bit 3 unused; external interrupt 0 priority bits 2-0.
// - Second register bit 11 unused; output compare 2 priority bits 10-8.
// - Second register bit 7 unused; input capture 2 priority in bits 6-4.
// - Second register bits 3 to 0 are unused and read zero.
// ============================================================================
module ipf_regs (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic      [1:0]  s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic      [31:0] s_axi_rdata,
  output logic      [1:0]  s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Levels towards the arbiter, zero when the source is disabled
  output logic      [2:0]  out_cmp1_level,
  output logic      [2:0]  in_cap1_level,
  output logic      [2:0]  ext_irq0_level,
  output logic      [2:0]  timer2_level,
  output logic      [2:0]  out_cmp2_level,
  output logic      [2:0]  in_cap2_level,
  // Per-source enable, low when the field holds zero
  output logic      [5:0]  src_enabled
);

  // ==========================================================================
  // Write channel capture
  // ==========================================================================
  // Address and data are latched separately, so either may arrive first.
  logic        aw_held;
  logic [3:0]  aw_addr;
  logic        w_held;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  logic        bvalid;
  logic [1:0]  bresp;
  logic        next_aw_held;
  logic [3:0]  next_aw_addr;
  logic        next_w_held;
  logic [31:0] next_w_data;
  logic [3:0]  next_w_strb;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        do_write;
  logic        wr_hit0;
  logic        wr_hit1;

  assign s_axi_awready = !aw_held && !bvalid;
  assign s_axi_wready  = !w_held && !bvalid;
  assign s_axi_bvalid  = bvalid;
  assign s_axi_bresp   = bresp;

  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (wr_hit0 || wr_hit1) ? ipf_pkg::RESP_OKAY
                                          : ipf_pkg::RESP_SLVERR;
    end else if (bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
      w_held  <= 1'b0;
      w_data  <= 32'h0000_0000;
      w_strb  <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= 2'h0;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held  <= next_w_held;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
    end
  end

  assign do_write = aw_held && w_held && !bvalid;
  assign wr_hit0  = aw_addr[3:2] == ipf_pkg::ADDR_PRIO0[3:2];
  assign wr_hit1  = aw_addr[3:2] == ipf_pkg::ADDR_PRIO1[3:2];

  // ==========================================================================
  // Priority fields
  // ==========================================================================
  // Each field sits inside one byte lane, so one strobe bit gates it.
  logic [2:0] code [6];
  logic [2:0] lvl  [6];
  logic [5:0] fld_we;
  logic [2:0] fld_wd [6];

  always_comb begin
    fld_we[0] = do_write && wr_hit0 && w_strb[1];
    fld_wd[0] = w_data[ipf_pkg::OUT_CMP1_LSB +: 3];
    fld_we[1] = do_write && wr_hit0 && w_strb[0];
    fld_wd[1] = w_data[ipf_pkg::IN_CAP1_LSB +: 3];
    fld_we[2] = do_write && wr_hit0 && w_strb[0];
    fld_wd[2] = w_data[ipf_pkg::EXT_IRQ0_LSB +: 3];
    fld_we[3] = do_write && wr_hit1 && w_strb[1];
    fld_wd[3] = w_data[ipf_pkg::TIMER2_LSB +: 3];
    fld_we[4] = do_write && wr_hit1 && w_strb[1];
    fld_wd[4] = w_data[ipf_pkg::OUT_CMP2_LSB +: 3];
    fld_we[5] = do_write && wr_hit1 && w_strb[0];
    fld_wd[5] = w_data[ipf_pkg::IN_CAP2_LSB +: 3];
  end

  for (genvar i = 0; i < 6; i++) begin : g_field
    ipf_prio_field u_field (
      .aclk    (aclk),
      .aresetn (aresetn),
      .wr_en   (fld_we[i]),
      .wr_code (fld_wd[i]),
      .code    (code[i]),
      .level   (lvl[i]),
      .enabled (src_enabled[i])
    );
  end

  // A disabled source presents level zero, so the arbiter cannot pick it.
  assign out_cmp1_level = lvl[0];
  assign in_cap1_level  = lvl[1];
  assign ext_irq0_level = lvl[2];
  assign timer2_level   = lvl[3];
  assign out_cmp2_level = lvl[4];
  assign in_cap2_level  = lvl[5];

  // ==========================================================================
  // Read images
  // ==========================================================================
  logic [15:0] img0;
  logic [15:0] img1;

  always_comb begin
    img0 = 16'h0000;
    img0[ipf_pkg::OUT_CMP1_LSB +: 3] = code[0];
    img0[ipf_pkg::IN_CAP1_LSB +: 3]  = code[1];
    img0[ipf_pkg::EXT_IRQ0_LSB +: 3] = code[2];
    img0 = img0 & ipf_pkg::PRIO0_MASK;
    img1 = 16'h0000;
    img1[ipf_pkg::TIMER2_LSB +: 3]   = code[3];
    img1[ipf_pkg::OUT_CMP2_LSB +: 3] = code[4];
    img1[ipf_pkg::IN_CAP2_LSB +: 3]  = code[5];
    img1 = img1 & ipf_pkg::PRIO1_MASK;
  end

  // ==========================================================================
  // Read channel
  // ==========================================================================
  logic        rvalid;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;

  assign s_axi_arready = !rvalid;
  assign s_axi_rvalid  = rvalid;
  assign s_axi_rdata   = rdata;
  assign s_axi_rresp   = rresp;

  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = ipf_pkg::RESP_OKAY;
      if (s_axi_araddr[3:2] == ipf_pkg::ADDR_PRIO0[3:2]) begin
        next_rdata = {16'h0000, img0};
      end else if (s_axi_araddr[3:2] == ipf_pkg::ADDR_PRIO1[3:2]) begin
        next_rdata = {16'h0000, img1};
      end else begin
        next_rdata = 32'h0000_0000;
        next_rresp = ipf_pkg::RESP_SLVERR;
      end
    end else if (rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= 2'h0;
    end else begin
      rvalid <= next_rvalid;
      rdata  <= next_rdata;
      rresp  <= next_rresp;
    end
  end

endmodule

// ---- ipf_regs_sva.sv ----
`timescale 1ns/1ns
// ==========================================================================
// Checker on the register block ports
// ==========================================================================
module ipf_regs_sva (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // Levels and enables
  input wire logic [2:0]  out_cmp1_level,
  input wire logic [2:0]  in_cap1_level,
  input wire logic [2:0]  ext_irq0_level,
  input wire logic [2:0]  timer2_level,
  input wire logic [2:0]  out_cmp2_level,
  input wire logic [2:0]  in_cap2_level,
  input wire logic [5:0]  src_enabled
);
  logic [5:0]  nz;
  logic [17:0] lv;
  assign lv = {out_cmp1_level, in_cap1_level, ext_irq0_level,
               timer2_level, out_cmp2_level, in_cap2_level};
  assign nz = {in_cap2_level != 3'h0, out_cmp2_level != 3'h0,
               timer2_level != 3'h0, ext_irq0_level != 3'h0,
               in_cap1_level != 3'h0, out_cmp1_level != 3'h0};
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Enable bit zero belongs to output compare 1, bit five to capture 2.
  en_map_a: assert property (src_enabled == nz)
    else $error("enable bits differ from nonzero levels");
  rst_level_a: assert property (disable iff (1'b0)
    !aresetn |=> lv == {6{3'h4}}) else $error("levels not four after reset");
  unimpl_zero_a: assert property (s_axi_rvalid |->
    (s_axi_rdata & 32'hffff8888) == 32'h0) else $error("unused bit read 1");
  lvl_hold_a: assert property (!$rose(s_axi_bvalid) |-> $stable(lv))
    else $error("level changed without a write");
  rd_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready wrong");
  wr_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> ##1 s_axi_bvalid) else $error("write answer late");
  b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("bvalid held after taken");
  r_drop_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("rvalid held after taken");
endmodule
bind ipf_regs ipf_regs_sva i_ipf_regs_sva (.*);

// ---- tb_top.sv ----
`timescale 1ns/1ns
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin miscompares++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [3:0]  s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, v;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  out_cmp1_level, in_cap1_level, ext_irq0_level, c0, c1, c2;
  logic [2:0]  timer2_level, out_cmp2_level, in_cap2_level;
  logic [5:0]  src_enabled;
  int          miscompares = 0;
  int          n_checks = 0;

  ipf_regs i_ipf_regs (.*);
  always #4 aclk = ~aclk;

  task automatic wr(input logic [3:0] a, input logic [31:0] d,
                    input logic [3:0] s, input logic [1:0] er);
    bit fin;
    fin = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!fin) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      fin = s_axi_bvalid;
    end
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, er)
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] ed,
                    input logic [1:0] er);
    bit fin;
    fin = 1'b0;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while (!fin) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      fin = s_axi_rvalid;
    end
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata, ed)
    `CHK(s_axi_rresp, er)
  endtask

  task automatic end_of_test;
    if (miscompares == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  // ========================================================================
  // Tests
  // ========================================================================
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ipf_pkg::ADDR_PRIO0, 32'h0444, ipf_pkg::RESP_OKAY);
    rd(ipf_pkg::ADDR_PRIO1, 32'h4440, ipf_pkg::RESP_OKAY);
    `CHK(src_enabled, 6'h3f)
    wr(ipf_pkg::ADDR_PRIO0, 32'hffffffff, 4'hf, ipf_pkg::RESP_OKAY);
    rd(ipf_pkg::ADDR_PRIO0, 32'h0777, ipf_pkg::RESP_OKAY);
    wr(ipf_pkg::ADDR_PRIO1, 32'hffffffff, 4'hf, ipf_pkg::RESP_OKAY);
    rd(ipf_pkg::ADDR_PRIO1, 32'h7770, ipf_pkg::RESP_OKAY);
    // Three different codes per register expose swapped or shifted fields.
    for (int c = 0; c < 8; c++) begin
      c0 = 3'(c);
      c1 = c0 + 3'h3;
      c2 = c0 + 3'h5;
      v = {20'h0, 1'b0, c0, 1'b0, c1, 1'b0, c2};
      wr(ipf_pkg::ADDR_PRIO0, v, 4'hf, ipf_pkg::RESP_OKAY);
      wr(ipf_pkg::ADDR_PRIO1, v << 4, 4'hf, ipf_pkg::RESP_OKAY);
      rd(ipf_pkg::ADDR_PRIO0, v, ipf_pkg::RESP_OKAY);
      rd(ipf_pkg::ADDR_PRIO1, v << 4, ipf_pkg::RESP_OKAY);
      `CHK({out_cmp1_level, in_cap1_level, ext_irq0_level}, {c0, c1, c2})
      `CHK({timer2_level, out_cmp2_level, in_cap2_level}, {c0, c1, c2})
      // Enable bit zero is output compare 1, bit five input capture 2.
      `CHK(src_enabled, {c2 != 3'h0, c1 != 3'h0, c0 != 3'h0, c2 != 3'h0, c1 != 3'h0, c0 != 3'h0})
    end
    wr(4'h8, 32'hffffffff, 4'hf, ipf_pkg::RESP_SLVERR);
    rd(4'h8, 32'h0, ipf_pkg::RESP_SLVERR);
    rd(ipf_pkg::ADDR_PRIO0, 32'h0724, ipf_pkg::RESP_OKAY);
    wr(ipf_pkg::ADDR_PRIO0, 32'h0000, 4'h1, ipf_pkg::RESP_OKAY);
    rd(ipf_pkg::ADDR_PRIO0, 32'h0700, ipf_pkg::RESP_OKAY);
    wr(ipf_pkg::ADDR_PRIO0, 32'h0, 4'hf, ipf_pkg::RESP_OKAY);
    wr(ipf_pkg::ADDR_PRIO1, 32'h0, 4'hf, ipf_pkg::RESP_OKAY);
    `CHK(src_enabled, 6'h00)
    `CHK(ext_irq0_level, ipf_pkg::LEVEL_OFF)
    // A second reset after every field was cleared must bring back level four.
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(ipf_pkg::ADDR_PRIO0, 32'h0444, ipf_pkg::RESP_OKAY);
    rd(ipf_pkg::ADDR_PRIO1, 32'h4440, ipf_pkg::RESP_OKAY);
    `CHK(src_enabled, 6'h3f)
    `CHK(timer2_level, ipf_pkg::FIELD_RESET)
    end_of_test;
  end

  // A healthy run needs under two hundred cycles; this gives ample margin.
  initial begin
    repeat (3000) @(posedge aclk);
    miscompares++;
    end_of_test;
  end
endmodule
